//--- test/mra_core_model.sv
// Core model issuing accesses and exception events
`default_nettype none
module mra_core_model (
  input  wire logic        clk_i,
  output logic             acc_valid_o,
  output logic [31:0]      acc_addr_o,
  output logic             acc_priv_o,
  output logic             acc_write_o,
  output logic             acc_fetch_o,
  output logic             exc_entry_o,
  output logic             exc_return_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {acc_valid_o, acc_priv_o, acc_write_o, acc_fetch_o} = 4'h0;
    {exc_entry_o, exc_return_o} = 2'h0;
    acc_addr_o = 32'h0000_0000;
  end
  ////////////////////////////////////////
  // One access from the next edge, settled by the falling edge
  task automatic present(input logic [31:0] a, input logic p, w, f);
    @(posedge clk_i);
    acc_valid_o <= 1'b1;
    acc_addr_o  <= a;
    acc_priv_o  <= p;
    acc_write_o <= w;
    acc_fetch_o <= f;
    @(negedge clk_i);
  endtask : present
  // Released address never shows the stale value
  task automatic idle();
    @(posedge clk_i);
    acc_valid_o <= 1'b0;
    acc_addr_o  <= ~acc_addr_o;
  endtask : idle
  // Exception entry or return for one cycle stands in for barriers
  task automatic exc(input logic ret);
    @(posedge clk_i);
    exc_entry_o  <= !ret;
    exc_return_o <= ret;
    @(posedge clk_i);
    {exc_entry_o, exc_return_o} <= 2'h0;
  endtask : exc
endmodule : mra_core_model
`default_nettype wire

//--- test/mra_region_check_bench.sv
// Self-checking bench for the region attribute checker
`default_nettype none
module mra_region_check_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import mra_pkg::*;
  logic        clk_i, nrst_i, wb_cyc, wb_stb, wb_we, wb_ack;
  logic        a_val, a_priv, a_wr, a_fe, e_in, e_ret;
  logic        flt, hit, shr, impl, irq, bar, h_s;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_dout, wb_rdat, a_addr;
  logic [2:0]  reg_o, r_s;
  mra_mtype_t  mt;
  mra_pol_t    inn, outp;
  int          err_total = 0;
  int          total_checks = 0;
  initial begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = '0;
    wb_sel = 4'hF;
    nrst_i = 1'b0;
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  mra_region_check #(.NUM_REGIONS(8)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dout), .wb_ack_o(wb_ack),
    .acc_valid_i(a_val), .acc_addr_i(a_addr), .acc_priv_i(a_priv),
    .acc_write_i(a_wr), .acc_fetch_i(a_fe), .exc_entry_i(e_in), .exc_return_i(e_ret),
    .acc_fault_o(flt), .acc_hit_o(hit), .acc_region_o(reg_o), .acc_mtype_o(mt),
    .acc_share_o(shr), .acc_inner_o(inn), .acc_outer_o(outp),
    .acc_impl_def_o(impl), .mmf_irq_o(irq), .barrier_o(bar));
  mra_core_model core_u (.clk_i(clk_i), .acc_valid_o(a_val), .acc_addr_o(a_addr),
    .acc_priv_o(a_priv), .acc_write_o(a_wr), .acc_fetch_o(a_fe),
    .exc_entry_o(e_in), .exc_return_o(e_ret));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we} <= {2'h3, w};
    wb_adr  <= a;
    wb_wdat <= d;
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    wb_rdat = wb_dout;
    {wb_cyc, wb_stb, wb_we} <= 3'h0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(wb_rdat, e);
  endtask : rd
  function automatic logic [31:0] at(logic xn, logic [2:0] ap, t, logic c, b, s,
                                     logic [4:0] sz);
    return {3'h0, xn, 1'h0, ap, 2'h0, t, s, c, b, 10'h000, sz, 1'b1};
  endfunction : at
  // Disable before rewrite
  task automatic region(input logic [2:0] n, input logic [31:0] base, attr);
    wr(OFS_RNR, {29'h0, n});
    wr(OFS_REGION_ATTRIBUTE_SIZE_REGISTER, 32'h0000_0000);
    wr(OFS_REGION_BASE_REGISTER, base);
    wr(OFS_REGION_ATTRIBUTE_SIZE_REGISTER, attr);
  endtask : region
  task automatic acc(input logic [31:0] a, input logic p, w, f, ef);
    core_u.present(a, p, w, f);
    chk(flt, ef);
    h_s = hit;
    r_s = reg_o;
    core_u.idle();
  endtask : acc
  function automatic logic pf(logic [2:0] ap, logic p, w);
    case (ap)
      3'h1: return !p;
      3'h2: return !p && w;
      3'h3: return 1'b0;
      3'h5: return !p || w;
      3'h6, 3'h7: return w;
      default: return 1'b1;
    endcase
  endfunction : pf
  ////////////////////////////////////////
  task automatic t_reset();
    rd(OFS_CTRL, 32'h0);
    rd(OFS_FSTAT, 32'h0);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0);
    chk({irq, bar}, 2'h0);
    acc(32'h2000_0000, 1'b0, 1'b1, 1'b0, 1'b0);
    acc(PPB_LO, 1'b1, 1'b0, 1'b1, 1'b1);
    core_u.present(PPB_LO + 32'h4, 1'b0, 1'b1, 1'b0);
    chk({flt, mt, shr}, {1'b0, MT_STRONG, 1'b1});
    core_u.idle();
    $display("reset and map test done");
  endtask : t_reset
  task automatic t_perm();
    wr(OFS_CTRL, 32'h1);
    for (int ap = 0; ap < 8; ap++) begin
      region(3'h0, 32'h2000_0000, at(1'b0, 3'(ap), 3'h0, 1'b1, 1'b0, 1'b0, 5'h09));
      for (int i = 0; i < 4; i++) begin
        acc(32'h2000_0010, i[1], i[0], 1'b0, pf(3'(ap), i[1], i[0]));
        chk({h_s, r_s}, 4'h8);
      end
    end
    $display("permission test done");
  endtask : t_perm
  task automatic t_decode();
    logic [2:0] t;
    logic c, b, s, es, ed;
    mra_mtype_t em;
    mra_pol_t ei, eo;
    for (int i = 0; i < 64; i++) begin
      {t, c, b, s} = 6'(i);
      em = MT_RSVD;
      {es, ed, ei, eo} = {s, 1'b0, POL_NC, POL_NC};
      if (t[2]) {em, ei, eo} = {MT_NORMAL, c, b, t[1:0]};
      else case ({t, c, b})
        5'h00: {em, es} = {MT_STRONG, 1'b1};
        5'h01: {em, es} = {MT_DEVICE, 1'b1};
        5'h02: {em, ei, eo} = {MT_NORMAL, POL_WT, POL_WT};
        5'h03: {em, ei, eo} = {MT_NORMAL, POL_WB, POL_WB};
        5'h04: em = MT_NORMAL;
        5'h06: {em, es, ed} = {MT_NORMAL, 2'h1};
        5'h07: {em, ei, eo} = {MT_NORMAL, POL_WBRWA, POL_WBRWA};
        5'h08: {em, es} = {MT_DEVICE, 1'b0};
        default: ;
      endcase
      region(3'h0, 32'h2000_0000, at(1'b0, AP_FULL, t, c, b, s, 5'h09));
      core_u.present(32'h2000_0020, 1'b1, 1'b0, 1'b0);
      chk({flt, mt, impl}, {1'b0, em, ed});
      if (em != MT_RSVD) chk(shr, es);
      if (em == MT_NORMAL) chk({inn, outp}, {ei, eo});
      core_u.idle();
    end
    $display("attribute decode test done");
  endtask : t_decode
  task automatic t_fault();
    region(3'h0, 32'h2000_0000, at(1'b1, AP_FULL, 3'h0, 1'b1, 1'b0, 1'b0, 5'h09));
    wr(OFS_FSTAT, 32'hFF);
    acc(32'h2000_0040, 1'b1, 1'b0, 1'b1, 1'b1);
    rd(OFS_FSTAT, 32'h01);
    acc(32'h4000_0000, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(irq, 1'b0);
    rd(OFS_FSTAT, 32'h83);
    rd(OFS_FADDR, 32'h4000_0000);
    wr(OFS_MASK, 32'h3);
    chk(irq, 1'b1);
    wr(OFS_FSTAT, 32'h03);
    chk(irq, 1'b0);
    rd(OFS_FSTAT, 32'h80);
    acc(32'h4000_0100, 1'b1, 1'b0, 1'b0, 1'b1);
    wr(OFS_CTRL, 32'h5);
    acc(32'h4000_0100, 1'b1, 1'b0, 1'b0, 1'b0);
    acc(32'h4000_0100, 1'b0, 1'b0, 1'b0, 1'b1);
    region(3'h0, 32'h2000_0000, at(1'b0, AP_FULL, 3'h0, 1'b1, 1'b0, 1'b0, 5'h09));
    acc(32'h2000_0040, 1'b0, 1'b0, 1'b1, 1'b0);
    $display("fault status test done");
  endtask : t_fault
  task automatic t_alias();
    logic [31:0] base;
    wr(OFS_CTRL, 32'h1);
    for (int k = 0; k < 4; k++) begin
      base = 32'h3000_0000 + 32'(k * 256);
      wr(OFS_REGION_BASE_REGISTER + 8'(8 * k), base | 32'h14 | 32'(k));
      wr(OFS_REGION_ATTRIBUTE_SIZE_REGISTER + 8'(8 * k), at(1'b0, AP_FULL, 3'h0, 1'b1, 1'b0, 1'b0, 5'h04));
    end
    rd(OFS_RNR, 32'h7);
    rd(OFS_REGION_BASE_REGISTER, 32'h3000_0307);
    rd(OFS_REGION_ATTRIBUTE_SIZE_REGISTER, at(1'b0, AP_FULL, 3'h0, 1'b1, 1'b0, 1'b0, 5'h04));
    for (int k = 0; k < 4; k++) begin
      base = 32'h3000_0000 + 32'(k * 256);
      acc(base + 32'h1F, 1'b1, 1'b1, 1'b0, 1'b0);
      chk({h_s, r_s}, {1'b1, 3'(4 + k)});
      acc(base + 32'h20, 1'b1, 1'b0, 1'b0, 1'b1);
      chk(h_s, 1'b0);
    end
    $display("alias and size test done");
  endtask : t_alias
  task automatic t_barrier();
    for (int r = 0; r < 2; r++) begin
      core_u.exc(r[0]);
      @(negedge clk_i);
      chk(bar, 1'b1);
      @(negedge clk_i);
      chk(bar, 1'b0);
    end
    $display("barrier test done");
  endtask : t_barrier
  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_perm();
    t_decode();
    t_fault();
    t_alias();
    t_barrier();
    summarize();
  end
  // Watchdog well beyond the roughly 1200 cycles the tests need
  initial begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    summarize();
  end
endmodule : mra_region_check_bench
`default_nettype wire

//--- verilog/mra_attr_decode.sv
// Memory type, cache policy and permission decode for one region
`default_nettype none
module mra_attr_decode (
  input  wire logic [2:0]          tex_i,
  input  wire logic                c_i,
  input  wire logic                b_i,
  input  wire logic                s_i,
  input  wire logic [2:0]          ap_i,
  input  wire logic                xn_i,
  input  wire logic                priv_i,
  input  wire logic                write_i,
  input  wire logic                fetch_i,
  output var  mra_pkg::mra_mtype_t mtype_o,
  output logic                     share_o,
  output var  mra_pkg::mra_pol_t   inner_o,
  output var  mra_pkg::mra_pol_t   outer_o,
  output logic                     impl_def_o,
  output logic                     perm_fault_o
);
  import mra_pkg::*;

  logic rd_ok;
  logic wr_ok;

  always_comb begin
    mtype_o    = MT_NORMAL;
    share_o    = s_i;
    inner_o    = POL_NC;
    outer_o    = POL_NC;
    impl_def_o = 1'b0;
    if (tex_i[2]) begin
      outer_o = mra_pol_t'(tex_i[1:0]);
      inner_o = mra_pol_t'({c_i, b_i});
    end else begin
      case (tex_i[1:0])
        2'b00: begin
          case ({c_i, b_i})
            2'b00: begin
              mtype_o = MT_STRONG;
              share_o = 1'b1;
            end
            2'b01: begin
              mtype_o = MT_DEVICE;
              share_o = 1'b1;
            end
            2'b10: begin
              inner_o = POL_WT;
              outer_o = POL_WT;
            end
            default: begin
              inner_o = POL_WB;
              outer_o = POL_WB;
            end
          endcase
        end
        2'b01: begin
          case ({c_i, b_i})
            2'b00: begin
              inner_o = POL_NC;
            end
            2'b11: begin
              inner_o = POL_WBRWA;
              outer_o = POL_WBRWA;
            end
            2'b10: begin
              impl_def_o = 1'b1;
              share_o    = 1'b0;
            end
            default: begin
              mtype_o = MT_RSVD;
              share_o = 1'b0;
            end
          endcase
        end
        2'b10: begin
          mtype_o = ({c_i, b_i} == 2'b00) ? MT_DEVICE : MT_RSVD;
          share_o = 1'b0;
        end
        default: begin
          mtype_o = MT_RSVD;
          share_o = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    case (ap_i)
      AP_NONE: begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
      AP_PRIV_RW: begin
        rd_ok = priv_i;
        wr_ok = priv_i;
      end
      AP_USER_RO: begin
        rd_ok = 1'b1;
        wr_ok = priv_i;
      end
      AP_FULL: begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      AP_PRIV_RO: begin
        rd_ok = priv_i;
        wr_ok = 1'b0;
      end
      AP_RO, AP_RO_ALT: begin
        rd_ok = 1'b1;
        wr_ok = 1'b0;
      end
      default: begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
  end

  // Fetches count as reads and are also barred by execute-never
  assign perm_fault_o = (write_i ? ~wr_ok : ~rd_ok) | (fetch_i & xn_i);
endmodule : mra_attr_decode
`default_nettype wire

//--- verilog/mra_pkg.sv
// Constants and types shared by the region attribute checker
// Contract
// - Fault any access to a region that lacks the rights the region grants.
// - Type 000 decodes strongly-ordered, device, write-through or write-back per C/B.
// - Type 001 and 010 decode per C/B; undefined combinations are reserved.
// - Type 1xx is normal; outer policy from type bits, inner from C/B.
// - Don't-care share or bufferable bits never change type or shareability.
// - Permission 000 none, 001 privileged only, 010 user read-only, 011 full.
// - Permission 101 privileged read-only, 110/111 read-only; 100 is denied.
// - A violation raises the fault exception and records its cause in status.
// - Region settings written singly or by burst, with three base/attr aliases.
// - Exception entry and return give barrier behaviour without explicit barriers.
// - Register space is strongly ordered; configuration writes complete in order.
// - Execute-never regions block instruction fetches.
// - With protection on, unprivileged accesses outside every region fault; unprivileged data accesses to private peripheral space do not.
// - Region size is two to the size field plus one bytes, 32 at least.
`default_nettype none
package mra_pkg;
  localparam int unsigned NUM_REGIONS_DEF = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h94;
  localparam logic [7:0] OFS_RNR     = 8'h98;
  localparam logic [7:0] OFS_REGION_BASE_REGISTER    = 8'h9C;
  localparam logic [7:0] OFS_REGION_ATTRIBUTE_SIZE_REGISTER    = 8'hA0;
  localparam logic [7:0] OFS_REGION_BASE_REGISTER_A1 = 8'hA4;
  localparam logic [7:0] OFS_REGION_ATTRIBUTE_SIZE_REGISTER_A1 = 8'hA8;
  localparam logic [7:0] OFS_REGION_BASE_REGISTER_A2 = 8'hAC;
  localparam logic [7:0] OFS_REGION_ATTRIBUTE_SIZE_REGISTER_A2 = 8'hB0;
  localparam logic [7:0] OFS_REGION_BASE_REGISTER_A3 = 8'hB4;
  localparam logic [7:0] OFS_REGION_ATTRIBUTE_SIZE_REGISTER_A3 = 8'hB8;
  localparam logic [7:0] OFS_FSTAT   = 8'hC0;
  localparam logic [7:0] OFS_FADDR   = 8'hC4;
  localparam logic [7:0] OFS_MASK    = 8'hC8;
  // Field positions
  localparam int unsigned CTRL_EN      = 0;
  localparam int unsigned CTRL_PRIVDEF = 2;
  localparam int unsigned REGION_BASE_REGISTER_VALID   = 4;
  localparam int unsigned BASE_LO      = 5;
  localparam int unsigned ATTR_XN      = 28;
  localparam int unsigned ATTR_AP_LO   = 24;
  localparam int unsigned ATTR_TEX_LO  = 19;
  localparam int unsigned ATTR_S       = 18;
  localparam int unsigned ATTR_C       = 17;
  localparam int unsigned ATTR_B       = 16;
  localparam int unsigned ATTR_SIZE_LO = 1;
  localparam int unsigned ATTR_EN      = 0;
  localparam logic [31:0] ATTR_WMASK   = 32'h173F_FF3F;
  localparam int unsigned FS_IACC      = 0;
  localparam int unsigned FS_DACC      = 1;
  localparam int unsigned FS_AVALID    = 7;
  localparam logic [7:0]  FS_EVT_MASK  = 8'h03;
  // Reset values
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  // Smallest size field accepted
  localparam logic [4:0]  MIN_SIZE     = 5'h04;
  // Private peripheral space
  localparam logic [31:0] PPB_LO       = 32'hE000_0000;
  localparam logic [31:0] PPB_HI       = 32'hE00F_FFFF;
  // Permission codes
  localparam logic [2:0] AP_NONE    = 3'h0;
  localparam logic [2:0] AP_PRIV_RW = 3'h1;
  localparam logic [2:0] AP_USER_RO = 3'h2;
  localparam logic [2:0] AP_FULL    = 3'h3;
  localparam logic [2:0] AP_RSVD    = 3'h4;
  localparam logic [2:0] AP_PRIV_RO = 3'h5;
  localparam logic [2:0] AP_RO      = 3'h6;
  localparam logic [2:0] AP_RO_ALT  = 3'h7;

  typedef enum logic [1:0] {
    MT_STRONG = 2'b00,
    MT_DEVICE = 2'b01,
    MT_NORMAL = 2'b10,
    MT_RSVD   = 2'b11
  } mra_mtype_t;

  typedef enum logic [1:0] {
    POL_NC    = 2'b00,
    POL_WBRWA = 2'b01,
    POL_WT    = 2'b10,
    POL_WB    = 2'b11
  } mra_pol_t;
endpackage : mra_pkg
`default_nettype wire

//--- verilog/mra_region_check.sv
// Region attribute checker with Wishbone register file
//
// Decided for this implementation: the Wishbone slave port and the address map.
`default_nettype none
module mra_region_check #(
  parameter int unsigned NUM_REGIONS = mra_pkg::NUM_REGIONS_DEF
) (
  input  wire logic                           clk_i,
  input  wire logic                           nrst_i,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [7:0]                     wb_adr_i,
  input  wire logic [3:0]                     wb_sel_i,
  input  wire logic [31:0]                    wb_dat_i,
  output logic      [31:0]                    wb_dat_o,
  output logic                                wb_ack_o,
  input  wire logic                           acc_valid_i,
  input  wire logic [31:0]                    acc_addr_i,
  input  wire logic                           acc_priv_i,
  input  wire logic                           acc_write_i,
  input  wire logic                           acc_fetch_i,
  input  wire logic                           exc_entry_i,
  input  wire logic                           exc_return_i,
  output logic                                acc_fault_o,
  output logic                                acc_hit_o,
  output logic      [$clog2(NUM_REGIONS)-1:0] acc_region_o,
  output var  mra_pkg::mra_mtype_t            acc_mtype_o,
  output logic                                acc_share_o,
  output var  mra_pkg::mra_pol_t              acc_inner_o,
  output var  mra_pkg::mra_pol_t              acc_outer_o,
  output logic                                acc_impl_def_o,
  output logic                                mmf_irq_o,
  output logic                                barrier_o
);
  import mra_pkg::*;

  localparam int unsigned RW = $clog2(NUM_REGIONS);

  typedef struct packed {
    logic                            ack;
    logic [31:0]                     rdata;
    logic                            en;
    logic                            privdef;
    logic [RW-1:0]                   region_number_register;
    logic [NUM_REGIONS-1:0][26:0]    base;
    logic [NUM_REGIONS-1:0][31:0]    attr;
    logic [7:0]                      fstat;
    logic [31:0]                     faddr;
    logic [7:0]                      mask;
    logic                            barrier;
  } mra_state_t;

  mra_state_t st_r;
  mra_state_t st_nxt;

  logic                   req;
  logic [31:0]            rd_val;
  logic [31:0]            wm;
  logic [RW-1:0]          tgt;
  logic [7:0]             fs_set;
  logic [7:0]             fs_clr;
  logic [NUM_REGIONS-1:0] hit;
  logic                   any_hit;
  logic [RW-1:0]          sel;
  logic [31:0]            sel_attr;
  logic                   in_ppb;
  logic                   fault;
  logic                   perm_fault;
  mra_mtype_t             dec_mtype;
  logic                   dec_share;
  mra_pol_t               dec_inner;
  mra_pol_t               dec_outer;
  logic                   dec_impl;
  logic [RW-1:0]          dat_rn;

  function automatic logic [31:0] mra_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_v;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        r[8*k +: 8] = new_v[8*k +: 8];
      end
    end
    return r;
  endfunction : mra_merge

  ////////////////////////////////////////////////////////////////////////////
  // Region match

  for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_match
    logic [4:0]  sz;
    logic [32:0] span;
    logic [31:0] msk;
    assign sz   = (st_r.attr[g][ATTR_SIZE_LO +: 5] < MIN_SIZE) ? MIN_SIZE
                : st_r.attr[g][ATTR_SIZE_LO +: 5];
    assign span = (33'h1_0000_0001 << ({1'b0, sz} + 6'h01)) - 33'h0_0000_0001;
    assign msk  = ~span[31:0];
    assign hit[g] = st_r.attr[g][ATTR_EN]
                  & (((acc_addr_i ^ {st_r.base[g], 5'h00}) & msk) == 32'h0000_0000);
  end

  // Highest numbered matching region wins
  always_comb begin
    sel = '0;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (hit[i]) begin
        sel = RW'(i);
      end
    end
  end

  assign any_hit  = |hit;
  assign sel_attr = st_r.attr[sel];
  assign in_ppb   = (acc_addr_i >= PPB_LO) && (acc_addr_i <= PPB_HI);

  mra_attr_decode u_dec (
    .tex_i        (sel_attr[ATTR_TEX_LO +: 3]),
    .c_i          (sel_attr[ATTR_C]),
    .b_i          (sel_attr[ATTR_B]),
    .s_i          (sel_attr[ATTR_S]),
    .ap_i         (sel_attr[ATTR_AP_LO +: 3]),
    .xn_i         (sel_attr[ATTR_XN]),
    .priv_i       (acc_priv_i),
    .write_i      (acc_write_i),
    .fetch_i      (acc_fetch_i),
    .mtype_o      (dec_mtype),
    .share_o      (dec_share),
    .inner_o      (dec_inner),
    .outer_o      (dec_outer),
    .impl_def_o   (dec_impl),
    .perm_fault_o (perm_fault)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Access check, same cycle as the match

  always_comb begin
    fault          = 1'b0;
    acc_mtype_o    = MT_NORMAL;
    acc_share_o    = 1'b0;
    acc_inner_o    = POL_NC;
    acc_outer_o    = POL_NC;
    acc_impl_def_o = 1'b0;
    if (in_ppb) begin
      // System space is always strongly ordered and never executable
      acc_mtype_o = MT_STRONG;
      acc_share_o = 1'b1;
      fault       = acc_fetch_i;
    end else if (!st_r.en) begin
      fault = 1'b0;
    end else if (any_hit) begin
      fault          = perm_fault;
      acc_mtype_o    = dec_mtype;
      acc_share_o    = dec_share;
      acc_inner_o    = dec_inner;
      acc_outer_o    = dec_outer;
      acc_impl_def_o = dec_impl;
    end else begin
      fault = ~acc_priv_i | ~st_r.privdef;
    end
  end

  assign acc_fault_o  = acc_valid_i & fault;
  assign acc_hit_o    = any_hit & st_r.en & ~in_ppb;
  assign acc_region_o = sel;

  ////////////////////////////////////////////////////////////////////////////
  // Register read value

  always_comb begin
    case (wb_adr_i)
      OFS_CTRL:  rd_val = {29'h0000_0000, st_r.privdef, 1'b0, st_r.en};
      OFS_RNR:   rd_val = {{(32-RW){1'b0}}, st_r.region_number_register};
      OFS_REGION_BASE_REGISTER, OFS_REGION_BASE_REGISTER_A1, OFS_REGION_BASE_REGISTER_A2, OFS_REGION_BASE_REGISTER_A3:
        rd_val = {st_r.base[st_r.region_number_register], 1'b0, 4'(st_r.region_number_register)};
      OFS_REGION_ATTRIBUTE_SIZE_REGISTER, OFS_REGION_ATTRIBUTE_SIZE_REGISTER_A1, OFS_REGION_ATTRIBUTE_SIZE_REGISTER_A2, OFS_REGION_ATTRIBUTE_SIZE_REGISTER_A3:
        rd_val = st_r.attr[st_r.region_number_register];
      OFS_FSTAT: rd_val = {24'h00_0000, st_r.fstat};
      OFS_FADDR: rd_val = st_r.faddr;
      OFS_MASK:  rd_val = {24'h00_0000, st_r.mask};
      default:   rd_val = RST_WORD;
    endcase
  end

  assign req = wb_cyc_i & wb_stb_i & ~st_r.ack;
  assign wm  = mra_merge(rd_val, wb_dat_i, wb_sel_i);
  assign tgt = wm[REGION_BASE_REGISTER_VALID] ? wm[RW-1:0] : st_r.region_number_register;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt         = st_r;
    fs_set         = 8'h00;
    fs_clr         = 8'h00;
    st_nxt.ack     = req;
    st_nxt.barrier = exc_entry_i | exc_return_i;
    if (req) begin
      st_nxt.rdata = rd_val;
    end
    if (req && wb_we_i) begin
      case (wb_adr_i)
        OFS_CTRL: begin
          st_nxt.en      = wm[CTRL_EN];
          st_nxt.privdef = wm[CTRL_PRIVDEF];
        end
        OFS_RNR: begin
          st_nxt.region_number_register = wm[RW-1:0];
        end
        OFS_REGION_BASE_REGISTER, OFS_REGION_BASE_REGISTER_A1, OFS_REGION_BASE_REGISTER_A2, OFS_REGION_BASE_REGISTER_A3: begin
          st_nxt.region_number_register       = tgt;
          st_nxt.base[tgt] = wm[31:BASE_LO];
        end
        OFS_REGION_ATTRIBUTE_SIZE_REGISTER, OFS_REGION_ATTRIBUTE_SIZE_REGISTER_A1, OFS_REGION_ATTRIBUTE_SIZE_REGISTER_A2, OFS_REGION_ATTRIBUTE_SIZE_REGISTER_A3: begin
          st_nxt.attr[st_r.region_number_register] = wm & ATTR_WMASK;
        end
        OFS_FSTAT: begin
          fs_clr = wb_dat_i[7:0] & {8{wb_sel_i[0]}};
        end
        OFS_MASK: begin
          st_nxt.mask = wm[7:0] & FS_EVT_MASK;
        end
        default: begin
          st_nxt.mask = st_r.mask;
        end
      endcase
    end
    if (acc_fault_o) begin
      if (acc_fetch_i) begin
        fs_set[FS_IACC] = 1'b1;
      end else begin
        fs_set[FS_DACC] = 1'b1;
        if (!st_r.fstat[FS_AVALID] || fs_clr[FS_AVALID]) begin
          fs_set[FS_AVALID] = 1'b1;
          st_nxt.faddr      = acc_addr_i;
        end
      end
    end
    // A new event wins over a clear in the same cycle
    st_nxt.fstat = (st_r.fstat & ~fs_clr) | fs_set;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o  = st_r.ack;
  assign wb_dat_o  = st_r.rdata;
  assign mmf_irq_o = |(st_r.fstat & st_r.mask & FS_EVT_MASK);
  assign barrier_o = st_r.barrier;
  assign dat_rn    = wb_dat_i[RW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held for more than one cycle");

  a_ack_after_req: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o
  ) else $error("request not answered in one cycle");

  a_dfault_status: assert property (
    (acc_fault_o && !acc_fetch_i) |=> st_r.fstat[FS_DACC] && st_r.fstat[FS_AVALID]
  ) else $error("data fault not recorded");

  a_ifault_irq: assert property (
    (acc_fault_o && acc_fetch_i && st_r.mask[FS_IACC]) |=> mmf_irq_o
  ) else $error("fetch fault raised no interrupt");

  a_ap_none_fault: assert property (
    (acc_valid_i && st_r.en && any_hit && !in_ppb
     && sel_attr[ATTR_AP_LO +: 3] == AP_NONE) |-> acc_fault_o
  ) else $error("no-access region let access through");

  a_ro_write_fault: assert property (
    (acc_valid_i && st_r.en && any_hit && !in_ppb && acc_write_i
     && sel_attr[ATTR_AP_LO +: 3] >= AP_RO) |-> acc_fault_o
  ) else $error("write to read-only region passed");

  a_user_nohit: assert property (
    (acc_valid_i && st_r.en && !any_hit && !in_ppb && !acc_priv_i) |-> acc_fault_o
  ) else $error("unprivileged access outside regions passed");

  a_xn_fetch: assert property (
    (acc_valid_i && st_r.en && any_hit && acc_fetch_i
     && sel_attr[ATTR_XN]) |-> acc_fault_o
  ) else $error("fetch from execute-never region passed");

  a_so_decode: assert property (
    (st_r.en && any_hit && !in_ppb && sel_attr[ATTR_TEX_LO +: 3] == 3'h0
     && !sel_attr[ATTR_C] && !sel_attr[ATTR_B])
    |-> (acc_mtype_o == MT_STRONG) && acc_share_o
  ) else $error("strongly-ordered decode wrong");

  a_region_base_register_valid: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == OFS_REGION_BASE_REGISTER
     && wb_sel_i[0] && wb_dat_i[REGION_BASE_REGISTER_VALID]) |=> st_r.region_number_register == $past(dat_rn)
  ) else $error("base write with valid did not move region number");

  a_barrier_exc: assert property (
    $rose(exc_entry_i) |=> barrier_o
  ) else $error("exception entry gave no barrier");
endmodule : mra_region_check
`default_nettype wire
